// *** dv/io_error_dump_writer_asserts.sv ***
// assertions on the dump writer ports: beats, trigger, length, mark, operator, link
// assumes the bind below reaches every writer instance
`timescale 1ns/1ps
module dump_asserts
    import dump_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int LEN_W = 20,
    parameter logic [MARK_W-1:0] CTRL_MARK = 32'h0000_10CB
) (
    // clock, reset, faults and memory port
    input wire logic CLOCK_IN, RST_IN, HW_FAULT_IN, ADDR_FAULT_IN, NORMAL_TERM_OK_IN,
    input wire logic MEM_READY_IN, MEM_VALID_OUT, DONE_OUT,
    input wire logic [ADDR_W-1:0] MEM_ADDR_OUT, DESC_ADDR_IN, OP_ADDR_OUT,
    input wire logic [WORD_W-1:0] MEM_DATA_OUT, CB_WORD_IN,
    // length, operator, mark and link
    input wire logic LEN_LOAD_IN, LEN_STEP_IN, OP_START_IN, OP_REQ_OUT, CB_CHECK_IN,
    input wire logic MARK_OK_OUT, MARK_BAD_OUT, LINK_TX_IN, LINK_OE_OUT,
    input wire logic [LEN_W-1:0] LEN_INIT_IN, LEN_OUT
);
    // sliced here so that $past sees a plain signal
    wire logic [MARK_W-1:0] cb_mark = CB_WORD_IN[MARK_LSB +: MARK_W];
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    property p_hold; MEM_VALID_OUT && !MEM_READY_IN |=> MEM_VALID_OUT
        && $stable(MEM_ADDR_OUT) && $stable(MEM_DATA_OUT); endproperty
    a_hold: assert property (p_hold) else $error("beat changed while stalled");
    property p_step; MEM_VALID_OUT && MEM_READY_IN |=> !MEM_VALID_OUT
        || MEM_ADDR_OUT == $past(MEM_ADDR_OUT) + 1'b1; endproperty
    a_step: assert property (p_step) else $error("address did not step");
    property p_end; $fell(MEM_VALID_OUT) |-> DONE_OUT ##1 !DONE_OUT; endproperty
    a_end: assert property (p_end) else $error("done pulse wrong");
    property p_trig; (HW_FAULT_IN || ADDR_FAULT_IN) && !NORMAL_TERM_OK_IN
        && !MEM_VALID_OUT && !DONE_OUT |=> MEM_VALID_OUT; endproperty
    a_trig: assert property (p_trig) else $error("fault did not start dump");
    property p_supp; NORMAL_TERM_OK_IN && !MEM_VALID_OUT |=> !MEM_VALID_OUT; endproperty
    a_supp: assert property (p_supp) else $error("dump while normal end ok");
    property p_mark; CB_CHECK_IN |=> MARK_OK_OUT == ($past(cb_mark) == CTRL_MARK)
        && MARK_BAD_OUT == !MARK_OK_OUT; endproperty
    a_mark: assert property (p_mark) else $error("mark verdict wrong");
    property p_load; LEN_LOAD_IN |=> LEN_OUT == $past(LEN_INIT_IN); endproperty
    a_load: assert property (p_load) else $error("length not loaded");
    property p_dec; LEN_STEP_IN && !LEN_LOAD_IN && LEN_OUT != 0
        |=> LEN_OUT == $past(LEN_OUT) - 1'b1; endproperty
    a_dec: assert property (p_dec) else $error("length not stepped");
    property p_op; OP_START_IN |=> OP_REQ_OUT && OP_ADDR_OUT == $past(DESC_ADDR_IN); endproperty
    a_op: assert property (p_op) else $error("operator start wrong");
    property p_oe; LINK_TX_IN |=> LINK_OE_OUT; endproperty
    a_oe: assert property (p_oe) else $error("link not driven");
    c_done: cover property (DONE_OUT);
    c_stall: cover property (MEM_VALID_OUT && !MEM_READY_IN);
    c_mark: cover property (MARK_OK_OUT);
endmodule
bind io_error_dump_writer dump_asserts #(.ADDR_W(ADDR_W), .LEN_W(LEN_W),
    .CTRL_MARK(CTRL_MARK)) i_chk (.CLOCK_IN, .RST_IN, .HW_FAULT_IN, .ADDR_FAULT_IN,
    .NORMAL_TERM_OK_IN, .MEM_READY_IN, .MEM_VALID_OUT, .DONE_OUT, .MEM_ADDR_OUT,
    .DESC_ADDR_IN, .OP_ADDR_OUT, .MEM_DATA_OUT, .CB_WORD_IN, .LEN_LOAD_IN, .LEN_STEP_IN,
    .OP_START_IN, .OP_REQ_OUT, .CB_CHECK_IN, .MARK_OK_OUT, .MARK_BAD_OUT, .LINK_TX_IN,
    .LINK_OE_OUT, .LEN_INIT_IN, .LEN_OUT);

// *** dv/mem_sink.sv ***
// system memory model on the dump write port, keeping the written image
// assumes one word a beat; with stall set it drops ready every other cycle
`timescale 1ns/1ps
module mem_sink (
    // write port
    input wire logic clk,
    input wire logic stall,
    input wire logic valid,
    input wire logic [19:0] addr,
    input wire logic [47:0] data,
    output logic ready
);
    logic [47:0] mem [32];
    int writes = 0;
    initial ready = 1'b0;
    // ready moves just after the edge, never on it
    always @(posedge clk) begin
        if (valid && ready) begin
            mem[addr[4:0]] <= data;
            writes <= writes + 1;
        end
        ready <= #1 stall ? ~ready : 1'b1;
    end
endmodule

// *** dv/test_io_error_dump_writer.sv ***
// bench for the dump writer: two dumps, length count, mark, operator and link
// assumes the package, writer, memory model and checker are compiled before it
`timescale 1ns/1ps
module test_io_error_dump_writer;
    import dump_pkg::*;
    localparam logic [31:0] MARK = 32'h0000_10CB; // arbitrary value
    logic clk = 0, rst = 1, hw = 0, af = 0, nok = 0, mw = 0, rw = 0, ll = 0, ls = 0;
    logic os = 0, cc = 0, tx = 0, pr = 0, stall = 0, rdy, v, busy, done, oreq, mok, mbad, oe;
    logic [47:0] hd = 0, z = 0, c = 0, md = 0, cw = 0, mdat;
    logic [23:0] ica = 0, icm = 0;
    logic [19:0] la = 0, rd = 0, li = 0, da = 0, ma, len, oa;
    logic [11:0] ua = 0;
    logic [3:0] pc = 0, ra = 0;
    logic [2:0] gp = 0;
    logic [24:0] far = 0, txd = 0, lo, prio;
    wire logic [24:0] link = oe ? lo : far;
    int num_errors = 0, compares = 0, cyc = 0, w0;
    io_error_dump_writer #(.CTRL_MARK(MARK)) i_dut (.CLOCK_IN(clk), .RST_IN(rst),
        .HW_FAULT_IN(hw), .ADDR_FAULT_IN(af), .NORMAL_TERM_OK_IN(nok), .HEADER_IN(hd),
        .LAST_ADDR_IN(la), .GLOBAL_PARAM_IN(gp), .PROM_CODE_IN(pc), .MICRO_ADDR_IN(ua),
        .IC_ADDR_REG_IN(ica), .IC_MATH_REG_IN(icm), .Z_REG_IN(z), .C_REG_IN(c),
        .MSTK_WR_IN(mw), .MSTK_DATA_IN(md), .RAM_WR_IN(rw), .RAM_ADDR_IN(ra), .RAM_DATA_IN(rd),
        .LEN_LOAD_IN(ll), .LEN_INIT_IN(li), .LEN_STEP_IN(ls), .OP_START_IN(os),
        .DESC_ADDR_IN(da), .CB_CHECK_IN(cc), .CB_WORD_IN(cw), .LINK_IN(link), .LINK_TX_IN(tx),
        .LINK_TX_DATA_IN(txd), .POLL_REQ_IN(pr), .MEM_READY_IN(rdy), .MEM_VALID_OUT(v),
        .MEM_ADDR_OUT(ma), .MEM_DATA_OUT(mdat), .BUSY_OUT(busy), .DONE_OUT(done),
        .LEN_OUT(len), .OP_REQ_OUT(oreq), .OP_ADDR_OUT(oa), .MARK_OK_OUT(mok),
        .MARK_BAD_OUT(mbad), .LINK_OUT(lo), .LINK_OE_OUT(oe), .PRIO_WORD_OUT(prio));
    mem_sink i_mem (.clk(clk), .stall(stall), .valid(v), .addr(ma), .data(mdat), .ready(rdy));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // inputs move 1 ns after the edge so the design samples settled values
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [19:0] ramv(input int i);
        return (i == 1) ? 20'h0_0400 : 20'h0_C0D0 + 20'(i);
    endfunction
    task automatic conclude();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // a hung handshake must still reach the verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            conclude();
        end
    end
    // live state, data registers, five micro-stack writes, length 0x40 less three
    task automatic t_fill();
        {hd, la, gp, pc, ua} = {48'h1234_5678_9ABC, 20'hA_BCDE, 3'h5, 4'h9, 12'h3C7};
        {ica, icm, z, c} = {24'h11_2233, 24'h44_5566, 48'hAAAA_5555_F00F, 48'h0FF0_1234_8765};
        rw = 1;
        for (int i = 0; i < 16; i++) begin
            {ra, rd} = {i[3:0], ramv(i)};
            tick();
        end
        {rw, mw} = 2'b01;
        for (int k = 0; k < 5; k++) begin
            md = 48'h0000_0000_00D0 + 48'(k);
            tick();
        end
        {mw, ll, li} = {2'b01, 20'h0_0040};
        tick();
        {ll, ls} = 2'b01;
        tick(3);
        ls = 0;
        chk(len, 20'h0_003D);
    endtask
    // held off while normal end is possible, then one whole block
    task automatic t_dump(input logic afault, input logic slow);
        int zw[5] = '{5, 7, 12, 30, 31};
        {stall, nok, hw, af} = {slow, 1'b1, ~afault, afault};
        w0 = i_mem.writes;
        tick(4);
        chk(v, 1'b0);
        nok = 0;
        tick();
        // the other cause arrives mid-dump and must be dropped, not queued
        {hw, af} = {afault, ~afault};
        chk(ma, 20'h0_0400);
        chk(busy, 1'b1);
        tick();
        {hw, af} = 2'b00;
        for (int n = 0; n < 200 && done !== 1'b1; n++) tick();
        chk(done, 1'b1);
        chk(busy, 1'b0);
        chk(i_mem.writes - w0, 32);
        chk(i_mem.mem[0], hd);
        chk(i_mem.mem[1], {7'h0, afault, 40'h0});
        chk(i_mem.mem[2], {la, 1'b0, gp, pc, 8'h00, ua});
        chk(i_mem.mem[3], {ica, icm});
        chk(i_mem.mem[4], z);
        chk(i_mem.mem[6], c);
        for (int k = 0; k < 4; k++) chk(i_mem.mem[8 + k], 48'h0000_0000_00D4 - 48'(k));
        for (int i = 0; i < 16; i++) chk(i_mem.mem[13 + i], {28'h0, ramv(i)});
        chk(i_mem.mem[29], {28'h0, 20'h0_003D});
        foreach (zw[j]) chk(i_mem.mem[zw[j]], 48'h0);
    endtask
    // count to its floor, then load against a step in the same cycle
    task automatic t_len();
        {ll, li} = {1'b1, 20'h0_0002};
        tick();
        {ll, ls} = 2'b01;
        tick(2);
        chk(len, 20'h0);
        tick();
        chk(len, 20'h0);
        ll = 1;
        tick();
        {ll, ls} = 2'b00;
        chk(len, 20'h0_0002);
    endtask
    // good then bad mark back to back, operator start, priority capture, link drive
    task automatic t_misc();
        {cc, cw, os, da} = {1'b1, MARK, 16'h1234, 1'b1, 20'h0_1357};
        tick();
        {cc, cw, os} = {1'b1, ~MARK, 16'h1234, 1'b0};
        chk({mok, mbad}, 2'b10);
        chk({oreq, oa}, {1'b1, 20'h0_1357});
        tick();
        {cc, far} = {1'b0, 25'h0AB_CDEF};
        chk({mok, mbad, oreq}, 3'b010);
        tick(3);
        pr = 1;
        tick();
        {pr, tx, txd} = {2'b01, 25'h1_2345};
        chk(prio, 25'h0AB_CDEF);
        tick();
        tx = 0;
        chk({oe, lo}, {1'b1, 25'h1_2345});
    endtask
    initial begin
        tick(16);
        rst = 0;
        tick();
        t_fill();
        t_dump(1'b0, 1'b0);
        t_dump(1'b1, 1'b1);
        t_len();
        t_misc();
        conclude();
    end
endmodule

// *** src/dump_pkg.sv ***
// package for the fault dump writer: word slots of the dump block, field positions,
// widths and the state encoding.
// assumes a 48-bit memory word and a 32-word dump block in system memory.
package dump_pkg;

    // word size and dump block length
    localparam int WORD_W = 48;
    localparam int DUMP_WORDS = 32;
    localparam logic [4:0] LAST_WORD = 5'h1F;

    // word slots inside the fault_dump_block
    localparam logic [4:0] W_HEADER = 5'h00;
    localparam logic [4:0] W_CAUSE = 5'h01;
    localparam logic [4:0] W_STATE = 5'h02;
    localparam logic [4:0] W_ICMEM = 5'h03;
    localparam logic [4:0] W_ZREG = 5'h04;
    localparam logic [4:0] W_CREG = 5'h06;
    localparam logic [4:0] W_MSTK_FIRST = 5'h08;
    localparam logic [4:0] W_MSTK_LAST = 5'h0B;
    localparam logic [4:0] W_RAM_FIRST = 5'h0D;
    localparam logic [4:0] W_RAM_LAST = 5'h1C;
    localparam logic [4:0] W_LENGTH = 5'h1D;

    // word two fields
    localparam int LASTADDR_LSB = 28;
    localparam int LASTADDR_W = 20;
    localparam int GPARAM_LSB = 24;
    localparam int GPARAM_W = 3;
    localparam int PROM_LSB = 20;
    localparam int PROM_W = 4;
    localparam int UADDR_W = 12;

    // word one cause field
    localparam int CAUSE_BIT = 40;

    // internal widths
    localparam int ICREG_W = 24;
    localparam int MSTK_DEPTH = 4;
    localparam int RAM_WORDS = 16;
    localparam logic [3:0] RAM_BASE_SLOT = 4'h1;
    localparam int LINK_W = 25;

    // control_block_mark field, bits [47:16]
    localparam int MARK_LSB = 16;
    localparam int MARK_W = 32;

    // dump sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WRITE = 2'b10
    } dump_st_t;

endpackage

// *** src/io_error_dump_writer.sv ***
// fault dump writer of the io_message_processor: keeps the internal state that the
// fault_dump_block records and writes the 32-word block to system memory on a fault.
// assumes a simple valid/ready memory write port on CLOCK_IN; link pins are asynchronous.
`timescale 1ns/1ps
module io_error_dump_writer
    import dump_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int LEN_W = 20,
    parameter int RAM_W = 20,
    parameter logic [MARK_W-1:0] CTRL_MARK = 32'h0000_10CB  // arbitrary value
) (
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    // fault causes
    input wire logic HW_FAULT_IN,
    input wire logic ADDR_FAULT_IN,
    input wire logic NORMAL_TERM_OK_IN,
    // live state sampled when a fault starts the dump
    input wire logic [WORD_W-1:0] HEADER_IN,
    input wire logic [LASTADDR_W-1:0] LAST_ADDR_IN,
    input wire logic [GPARAM_W-1:0] GLOBAL_PARAM_IN,
    input wire logic [PROM_W-1:0] PROM_CODE_IN,
    input wire logic [UADDR_W-1:0] MICRO_ADDR_IN,
    input wire logic [ICREG_W-1:0] IC_ADDR_REG_IN,
    input wire logic [ICREG_W-1:0] IC_MATH_REG_IN,
    input wire logic [WORD_W-1:0] Z_REG_IN,
    input wire logic [WORD_W-1:0] C_REG_IN,
    // micro-stack and data-register writes
    input wire logic MSTK_WR_IN,
    input wire logic [WORD_W-1:0] MSTK_DATA_IN,
    input wire logic RAM_WR_IN,
    input wire logic [3:0] RAM_ADDR_IN,
    input wire logic [RAM_W-1:0] RAM_DATA_IN,
    // length count
    input wire logic LEN_LOAD_IN,
    input wire logic [LEN_W-1:0] LEN_INIT_IN,
    input wire logic LEN_STEP_IN,
    // universal_io_operator start and control block check
    input wire logic OP_START_IN,
    input wire logic [ADDR_W-1:0] DESC_ADDR_IN,
    input wire logic CB_CHECK_IN,
    input wire logic [WORD_W-1:0] CB_WORD_IN,
    // message_link_interface pins
    input wire logic [LINK_W-1:0] LINK_IN,
    input wire logic LINK_TX_IN,
    input wire logic [LINK_W-1:0] LINK_TX_DATA_IN,
    input wire logic POLL_REQ_IN,
    // memory write port
    input wire logic MEM_READY_IN,
    output logic MEM_VALID_OUT,
    output logic [ADDR_W-1:0] MEM_ADDR_OUT,
    output logic [WORD_W-1:0] MEM_DATA_OUT,
    // status
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic [LEN_W-1:0] LEN_OUT,
    output logic OP_REQ_OUT,
    output logic [ADDR_W-1:0] OP_ADDR_OUT,
    output logic MARK_OK_OUT,
    output logic MARK_BAD_OUT,
    output logic [LINK_W-1:0] LINK_OUT,
    output logic LINK_OE_OUT,
    output logic [LINK_W-1:0] PRIO_WORD_OUT
);

    typedef struct packed {
        dump_st_t st;
        logic [4:0] idx;
        logic cause;
        logic [WORD_W-1:0] hdr;
        logic [LASTADDR_W-1:0] last_addr;
        logic [GPARAM_W-1:0] gparam;
        logic [PROM_W-1:0] prom;
        logic [UADDR_W-1:0] uaddr;
        logic [ICREG_W-1:0] ic_addr;
        logic [ICREG_W-1:0] ic_math;
        logic [WORD_W-1:0] z;
        logic [WORD_W-1:0] c;
        logic [LEN_W-1:0] len_snap;
        logic [LEN_W-1:0] len;
        logic [MSTK_DEPTH-1:0][WORD_W-1:0] mstk;
        logic [RAM_WORDS-1:0][RAM_W-1:0] ram;
        logic mem_valid;
        logic [ADDR_W-1:0] mem_addr;
        logic [WORD_W-1:0] mem_data;
        logic done;
        logic op_req;
        logic [ADDR_W-1:0] op_addr;
        logic mark_ok;
        logic mark_bad;
        logic [LINK_W-1:0] link_s1;
        logic [LINK_W-1:0] link_s2;
        logic [LINK_W-1:0] link_out;
        logic link_oe;
        logic [LINK_W-1:0] prio;
    } state_t;

    state_t r;
    state_t next_r;

    // assembles one dump word from the frozen snapshot and the live micro-stack and data registers; undefined slots read zero
    function automatic logic [WORD_W-1:0] dump_word(input state_t s, input logic [4:0] i);
        logic [WORD_W-1:0] w;
        w = '0;
        if (i == W_HEADER) begin
            w = s.hdr;
        end else if (i == W_CAUSE) begin
            w[CAUSE_BIT] = s.cause;
        end else if (i == W_STATE) begin
            w[LASTADDR_LSB +: LASTADDR_W] = s.last_addr;
            w[GPARAM_LSB +: GPARAM_W] = s.gparam;
            w[PROM_LSB +: PROM_W] = s.prom;
            w[UADDR_W-1:0] = s.uaddr;
        end else if (i == W_ICMEM) begin
            w = {s.ic_addr, s.ic_math};
        end else if (i == W_ZREG) begin
            w = s.z;
        end else if (i == W_CREG) begin
            w = s.c;
        end else if (i >= W_MSTK_FIRST && i <= W_MSTK_LAST) begin
            w = s.mstk[2'(i - W_MSTK_FIRST)];
        end else if (i >= W_RAM_FIRST && i <= W_RAM_LAST) begin
            w[RAM_W-1:0] = s.ram[4'(i - W_RAM_FIRST)];
        end else if (i == W_LENGTH) begin
            w[LEN_W-1:0] = s.len_snap;
        end
        return w;
    endfunction

    // next-state logic for the whole block
    always_comb begin
        logic fault;
        fault = 1'b0;
        next_r = r;
        next_r.done = 1'b0;
        next_r.op_req = 1'b0;
        next_r.mark_ok = 1'b0;
        next_r.mark_bad = 1'b0;

        // micro-stack history: slot 0 is always the newest write
        if (MSTK_WR_IN) begin
            next_r.mstk = {r.mstk[MSTK_DEPTH-2:0], MSTK_DATA_IN};
        end
        if (RAM_WR_IN) begin
            next_r.ram[RAM_ADDR_IN] = RAM_DATA_IN;
        end

        // length count: load wins over a step in the same cycle, floor at zero
        if (LEN_LOAD_IN) begin
            next_r.len = LEN_INIT_IN;
        end else if (LEN_STEP_IN && r.len != '0) begin
            next_r.len = r.len - 1'b1;
        end

        // operator start and mark check are one-cycle answers
        if (OP_START_IN) begin
            next_r.op_req = 1'b1;
            next_r.op_addr = DESC_ADDR_IN;
        end
        if (CB_CHECK_IN) begin
            next_r.mark_ok = (CB_WORD_IN[MARK_LSB +: MARK_W] == CTRL_MARK);
            next_r.mark_bad = (CB_WORD_IN[MARK_LSB +: MARK_W] != CTRL_MARK);
        end

        // link pins: two-stage sync before the priority capture reads them
        next_r.link_s1 = LINK_IN;
        next_r.link_s2 = r.link_s1;
        next_r.link_out = LINK_TX_DATA_IN;
        next_r.link_oe = LINK_TX_IN;
        if (POLL_REQ_IN) begin
            next_r.prio = r.link_s2;
        end

        // dump sequencer; faults during a dump are dropped, the first one is kept
        fault = (HW_FAULT_IN || ADDR_FAULT_IN) && !NORMAL_TERM_OK_IN;
        case (r.st)
            ST_IDLE: begin
                if (fault) begin
                    next_r.st = ST_WRITE;
                    next_r.idx = '0;
                    next_r.cause = ADDR_FAULT_IN && !HW_FAULT_IN;
                    next_r.hdr = HEADER_IN;
                    next_r.last_addr = LAST_ADDR_IN;
                    next_r.gparam = GLOBAL_PARAM_IN;
                    next_r.prom = PROM_CODE_IN;
                    next_r.uaddr = MICRO_ADDR_IN;
                    next_r.ic_addr = IC_ADDR_REG_IN;
                    next_r.ic_math = IC_MATH_REG_IN;
                    next_r.z = Z_REG_IN;
                    next_r.c = C_REG_IN;
                    next_r.len_snap = r.len;
                    next_r.mem_valid = 1'b1;
                    next_r.mem_addr = r.ram[RAM_BASE_SLOT][ADDR_W-1:0];
                    next_r.mem_data = dump_word(next_r, '0);
                end
            end
            ST_WRITE: begin
                if (MEM_READY_IN) begin
                    if (r.idx == LAST_WORD) begin
                        next_r.st = ST_IDLE;
                        next_r.mem_valid = 1'b0;
                        next_r.done = 1'b1;
                    end else begin
                        next_r.idx = r.idx + 1'b1;
                        next_r.mem_addr = ADDR_W'(r.mem_addr + 1'b1);
                        next_r.mem_data = dump_word(r, 5'(r.idx + 1'b1));
                    end
                end
            end
            default: begin
                next_r.st = ST_IDLE;
                next_r.mem_valid = 1'b0;
            end
        endcase
    end

    // single state register; reset to constants only
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            r <= '0;
            r.st <= ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flip-flops
    assign MEM_VALID_OUT = r.mem_valid;
    assign MEM_ADDR_OUT = r.mem_addr;
    assign MEM_DATA_OUT = r.mem_data;
    assign BUSY_OUT = r.mem_valid;
    assign DONE_OUT = r.done;
    assign LEN_OUT = r.len;
    assign OP_REQ_OUT = r.op_req;
    assign OP_ADDR_OUT = r.op_addr;
    assign MARK_OK_OUT = r.mark_ok;
    assign MARK_BAD_OUT = r.mark_bad;
    assign LINK_OUT = r.link_out;
    assign LINK_OE_OUT = r.link_oe;
    assign PRIO_WORD_OUT = r.prio;

endmodule
